//--- pbcc_pkg.sv
package pbcc_pkg;
	// register address of the bypass channel three control register
	localparam logic [7:0] PBCC_REG_ADDR     = 8'h23;
	// field positions inside the control register
	localparam int         PBCC_EN_BIT       = 7;
	localparam int         PBCC_IEN_BIT      = 6;
	localparam int         PBCC_FORCE_BIT    = 1;
	localparam int         PBCC_DET_BIT      = 0;
	// reset values of the stored fields
	localparam logic       PBCC_EN_RST       = 1'h0;
	localparam logic       PBCC_IEN_RST      = 1'h0;
	localparam logic       PBCC_FORCE_RST    = 1'h1;
	// pins power up as inputs with weak pull-ups, so the filter idles high
	localparam logic       PBCC_PIN_RST      = 1'h1;
	// value loaded into the shared interrupt source register
	localparam logic [7:0] PBCC_IRQ_SRC_VAL  = PBCC_REG_ADDR;
	// loss-of-signal to bypass output latency budget
	localparam int         PBCC_CLK_MHZ      = 40;
	localparam int         PBCC_LOSS_LAT_NS  = 400;
	// longest time, so round down
	localparam int         PBCC_LOSS_LAT_CYC =
		(PBCC_LOSS_LAT_NS * PBCC_CLK_MHZ) / 1000;
	// default number of agreeing samples the glitch filter needs
	localparam int         PBCC_FILT_DEPTH   = 4;
	// pin indices inside the two-bit pin groups
	localparam int         PBCC_PIN_BYP      = 0;
	localparam int         PBCC_PIN_DET      = 1;
endpackage : pbcc_pkg

//--- pbcc_in_filter.sv
// two-flop synchroniser followed by an agreement glitch filter
module pbcc_in_filter #(
	parameter int W     = 2,
	parameter int DEPTH = pbcc_pkg::PBCC_FILT_DEPTH
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_raw,
	output logic      [W-1:0] pin_filt
);
	// refuse depths that the agreement check cannot serve
	if (DEPTH < 2 || W < 1) begin : g_bad_param
		$error("pbcc_in_filter: DEPTH must be >= 2 and W >= 1");
	end

	logic [W-1:0] sync1_q;              // first stage, read only by second
	logic [W-1:0] sync2_q;              // metastability-safe copy
	logic [W-1:0] hist_q [DEPTH];       // recent synchronised samples
	logic [W-1:0] hist_d [DEPTH];
	logic [W-1:0] filt_q;               // filtered level
	logic [W-1:0] filt_d;

	// shift history; a bit changes only when every sample agrees
	always_comb begin
		hist_d[0] = sync2_q;
		for (int i = 1; i < DEPTH; i++) begin
			hist_d[i] = hist_q[i-1];
		end
		for (int b = 0; b < W; b++) begin
			filt_d[b] = filt_q[b];
			if (hist_q[0][b] == hist_q[DEPTH-1][b]) begin
				filt_d[b] = hist_q[0][b];
				for (int i = 1; i < DEPTH-1; i++) begin
					if (hist_q[i][b] != hist_q[0][b])
						filt_d[b] = filt_q[b];
				end
			end
		end
	end

	// registers; pins idle high thanks to the pull-ups
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_q <= {W{pbcc_pkg::PBCC_PIN_RST}};
			sync2_q <= {W{pbcc_pkg::PBCC_PIN_RST}};
			for (int i = 0; i < DEPTH; i++) begin
				hist_q[i] <= {W{pbcc_pkg::PBCC_PIN_RST}};
			end
			filt_q  <= {W{pbcc_pkg::PBCC_PIN_RST}};
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			hist_q  <= hist_d;
			filt_q  <= filt_d;
		end
	end

	assign pin_filt = filt_q;
endmodule : pbcc_in_filter

//--- pbcc_channel.sv
module pbcc_channel #(
	parameter int FILT_DEPTH = pbcc_pkg::PBCC_FILT_DEPTH
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd_en,
	output logic      [7:0] reg_rdata,
	// general port configuration of the two pins, index 0 bypass, 1 detect
	input  wire logic [1:0] gp_out,
	input  wire logic [1:0] gp_oe,
	// bypass select function from the bit control registers
	input  wire logic [1:0] bypass_sel_active,
	input  wire logic [1:0] bypass_sel_out,
	input  wire logic [1:0] bypass_sel_oe,
	// bypass output pin
	input  wire logic       bypass_output_pin_in,
	output logic            bypass_output_pin_out,
	output logic            bypass_output_pin_oe,
	// signal detected input pin
	input  wire logic       detect_input_pin_in,
	output logic            detect_input_pin_out,
	output logic            detect_input_pin_oe,
	// interrupt and shared source register load
	output logic            int_n,
	input  wire logic       irq_ack,
	output logic            irq_src_load,
	output logic      [7:0] irq_src_value
);
	// pin to clear: 2 sync + depth + agreement + flag flop must fit budget
	if (FILT_DEPTH + 4 > pbcc_pkg::PBCC_LOSS_LAT_CYC) begin : g_bad_depth
		$error("pbcc_channel: FILT_DEPTH too deep for latency");
	end

	logic [1:0] pin_filt;         // filtered levels of both pins
	logic       det_f;            // filtered signal detected
	logic       det_prev_q;       // previous filtered detect, edge finder
	logic       det_prev_d;
	logic       en_q;             // channel enable
	logic       en_d;
	logic       ien_q;            // detect interrupt enable
	logic       ien_d;
	logic       force_q;          // force bypass control, one = normal
	logic       force_d;
	logic       pend_q;           // interrupt pending
	logic       pend_d;
	logic       src_ld_q;         // one-cycle load of the source register
	logic       src_ld_d;
	logic [7:0] src_val_q;        // value presented to the source register
	logic [7:0] src_val_d;
	logic [7:0] rdata_q;          // read data, held until next read
	logic [7:0] rdata_d;
	logic       hit;              // access addresses this register
	logic       det_edge;         // transition on filtered detect

	pbcc_in_filter #(
		.W     (2),
		.DEPTH (FILT_DEPTH)
	) u_filt (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.pin_raw  ({detect_input_pin_in, bypass_output_pin_in}),
		.pin_filt (pin_filt)
	);

	assign det_f    = pin_filt[pbcc_pkg::PBCC_PIN_DET];
	assign hit      = (reg_addr == pbcc_pkg::PBCC_REG_ADDR);
	assign det_edge = (det_f != det_prev_q);

	// control fields, interrupt and read data next values
	always_comb begin
		en_d      = en_q;
		ien_d     = ien_q;
		force_d    = force_q;
		pend_d     = pend_q;
		src_ld_d   = 1'h0;
		src_val_d  = src_val_q;
		rdata_d    = rdata_q;
		det_prev_d = det_f;
		// bits 5..2 and the detect bit are not stored on writes
		if (reg_wr_en && hit) begin
			en_d    = reg_wdata[pbcc_pkg::PBCC_EN_BIT];
			ien_d   = reg_wdata[pbcc_pkg::PBCC_IEN_BIT];
			force_d = reg_wdata[pbcc_pkg::PBCC_FORCE_BIT];
		end
		// hardware clear beats a write so loss of signal is never missed
		if (en_q && !det_f) begin
			force_d = 1'h0;
		end
		// acknowledge clears, but a fresh event in the same cycle wins
		if (irq_ack) begin
			pend_d = 1'h0;
		end
		if (en_q && ien_q && det_edge) begin
			pend_d    = 1'h1;
			src_ld_d  = 1'h1;
			src_val_d = pbcc_pkg::PBCC_IRQ_SRC_VAL;
		end
		// read: unmapped addresses answer zero
		if (reg_rd_en) begin
			rdata_d = 8'h00;
			if (hit) begin
				rdata_d[pbcc_pkg::PBCC_EN_BIT]  = en_q;
				rdata_d[pbcc_pkg::PBCC_IEN_BIT] = ien_q;
				// disabled: show the filtered pin so software learns
				// the pull-resistor default before enabling
				rdata_d[pbcc_pkg::PBCC_FORCE_BIT] = en_q ? force_q :
					pin_filt[pbcc_pkg::PBCC_PIN_BYP];
				rdata_d[pbcc_pkg::PBCC_DET_BIT]   = det_f;
			end
		end
	end

	// register the control group
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_q      <= pbcc_pkg::PBCC_EN_RST;
			ien_q     <= pbcc_pkg::PBCC_IEN_RST;
			force_q    <= pbcc_pkg::PBCC_FORCE_RST;
			pend_q     <= 1'h0;
			src_ld_q   <= 1'h0;
			src_val_q  <= 8'h00;
			rdata_q    <= 8'h00;
			det_prev_q <= pbcc_pkg::PBCC_PIN_RST;
		end else begin
			en_q       <= en_d;
			ien_q      <= ien_d;
			force_q    <= force_d;
			pend_q     <= pend_d;
			src_ld_q   <= src_ld_d;
			src_val_q  <= src_val_d;
			rdata_q    <= rdata_d;
			det_prev_q <= det_prev_d;
		end
	end

	// pin steering: while enabled, bypass select first, then the channel; disabled, gpio only
	always_comb begin
		bypass_output_pin_out = gp_out[pbcc_pkg::PBCC_PIN_BYP];
		bypass_output_pin_oe  = gp_oe[pbcc_pkg::PBCC_PIN_BYP];
		detect_input_pin_out  = gp_out[pbcc_pkg::PBCC_PIN_DET];
		detect_input_pin_oe   = gp_oe[pbcc_pkg::PBCC_PIN_DET];
		if (en_q) begin
			// totem-pole drive; zero puts the external circuit in bypass
			bypass_output_pin_out = force_q;
			bypass_output_pin_oe  = 1'h1;
			detect_input_pin_out  = 1'h0;
			detect_input_pin_oe   = 1'h0;
			if (bypass_sel_active[pbcc_pkg::PBCC_PIN_BYP]) begin
				bypass_output_pin_out =
					bypass_sel_out[pbcc_pkg::PBCC_PIN_BYP];
				bypass_output_pin_oe  =
					bypass_sel_oe[pbcc_pkg::PBCC_PIN_BYP];
			end
			if (bypass_sel_active[pbcc_pkg::PBCC_PIN_DET]) begin
				detect_input_pin_out =
					bypass_sel_out[pbcc_pkg::PBCC_PIN_DET];
				detect_input_pin_oe  =
					bypass_sel_oe[pbcc_pkg::PBCC_PIN_DET];
			end
		end
	end

	assign int_n         = ~pend_q;
	assign irq_src_load  = src_ld_q;
	assign irq_src_value = src_val_q;
	assign reg_rdata     = rdata_q;

	// helper: consecutive cycles the raw detect pin has been low, enabled
	logic [7:0] low_cnt_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			low_cnt_q <= 8'h00;
		else if (!en_q || detect_input_pin_in)
			low_cnt_q <= 8'h00;
		else if (low_cnt_q != 8'hFF)
			low_cnt_q <= low_cnt_q + 8'h01;
	end

	AST_FORCE_AUTO_CLR: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		en_q && !det_f |=> !force_q)
		else $error("force bypass not cleared on filtered loss");

	AST_LOSS_LAT: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		low_cnt_q == 8'(pbcc_pkg::PBCC_LOSS_LAT_CYC)
		|-> bypass_sel_active[0] || !bypass_output_pin_out)
		else $error("bypass output late after loss of signal");

	AST_OUT_DRIVE: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		en_q && !bypass_sel_active[0]
		|-> bypass_output_pin_oe && bypass_output_pin_out == force_q)
		else $error("bypass pin not driven from force bypass");

	AST_DET_INPUT: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		en_q && !bypass_sel_active[1] |-> !detect_input_pin_oe)
		else $error("detect pin driven while channel enabled");

	AST_SEL_WINS: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		en_q && bypass_sel_active[0]
		|-> bypass_output_pin_oe == bypass_sel_oe[0]
		&& bypass_output_pin_out == bypass_sel_out[0])
		else $error("bypass select lost its pin");

	AST_DISABLED: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!en_q |-> bypass_output_pin_oe == gp_oe[0]
		&& detect_input_pin_oe == gp_oe[1] ##1 !$rose(pend_q))
		else $error("disabled channel touched pins or interrupt");

	AST_IRQ_SET: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		en_q && ien_q && det_f != $past(det_f) ##1 1'b1 |-> !int_n)
		else $error("detect transition raised no interrupt");

	AST_NO_IRQ: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(pend_q) |-> $past(ien_q) && $past(en_q))
		else $error("interrupt with detect interrupt disabled");

	AST_SRC_LOAD: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(pend_q) |-> irq_src_load && irq_src_value == 8'h23)
		else $error("source register not loaded with 23h");

	AST_RD_DET: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		reg_rd_en && hit |=> reg_rdata[0] == $past(det_f)
		&& reg_rdata[5:2] == 4'h0)
		else $error("read of detect bit wrong");
endmodule : pbcc_channel

//--- pbcc_ext_model.sv
// behavioural bypass circuit with its signal detect unit on the two pins
module pbcc_ext_model (
	input  wire logic det_level,   // signal detect level commanded by bench
	input  wire logic byp_out,     // channel drive of the bypass pin
	input  wire logic byp_oe,      // channel enable of the bypass pin
	input  wire logic det_out,     // channel drive of the detect pin
	input  wire logic det_oe,      // channel enable of the detect pin
	output logic      byp_pin,     // resolved bypass pin level
	output logic      det_pin,     // resolved detect pin level
	output logic      bypass_mode  // circuit state seen by the far side
);
	timeunit 1ns;
	timeprecision 1ps;
	// weak pull-up holds the bypass pin high while nobody drives it
	assign byp_pin = byp_oe ? byp_out : 1'h1;
	// channel drive wins only if it wrongly drives; the unit drives always
	assign det_pin = det_oe ? det_out : det_level;
	// low on the force input places the circuit in bypass
	assign bypass_mode = ~byp_pin;
endmodule : pbcc_ext_model

//--- test_port_bypass_control_channel.sv
module test_port_bypass_control_channel;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk, sys_rst, wr_en, rd_en, irq_ack, det_lvl;
	logic [7:0] addr, wdata, rdata, src_val;
	logic [1:0] gp_out, gp_oe, bs_act, bs_out, bs_oe;
	logic       byp_pin, det_pin, byp_out, byp_oe, det_out, det_oe;
	logic       int_n, src_load, byp_mode;
	int         n_fail, n_compared, cyc;
	// device under test with the default filter depth
	pbcc_channel dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(addr), .reg_wr_en(wr_en), .reg_wdata(wdata),
		.reg_rd_en(rd_en), .reg_rdata(rdata), .gp_out(gp_out),
		.gp_oe(gp_oe), .bypass_sel_active(bs_act),
		.bypass_sel_out(bs_out), .bypass_sel_oe(bs_oe),
		.bypass_output_pin_in(byp_pin), .bypass_output_pin_out(byp_out),
		.bypass_output_pin_oe(byp_oe), .detect_input_pin_in(det_pin),
		.detect_input_pin_out(det_out), .detect_input_pin_oe(det_oe),
		.int_n(int_n), .irq_ack(irq_ack), .irq_src_load(src_load),
		.irq_src_value(src_val));
	// far side of the pins
	pbcc_ext_model ext_u (.det_level(det_lvl), .byp_out(byp_out),
		.byp_oe(byp_oe), .det_out(det_out), .det_oe(det_oe),
		.byp_pin(byp_pin), .det_pin(det_pin), .bypass_mode(byp_mode));
	// 40 MHz clock
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// verdict and end of run
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1
	// write strobe sampled at the second edge, effect visible from that same edge on
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'h1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'h0;
		@(posedge ref_clk);
		#1;
	endtask : wr
	// read strobe, data taken once it has settled after the answer edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		rd_en <= 1'h1;
		addr  <= a;
		@(posedge ref_clk);
		rd_en <= 1'h0;
		@(posedge ref_clk);
		#1;
		d = rdata;
	endtask : rd
	// bounded wait; which: 0 bypass out, 1 source load, 2 interrupt
	task automatic wait_sig(input int which, input logic v, input int lim);
		logic s;
		cyc = 0;
		do begin
			@(posedge ref_clk);
			#1;
			cyc++;
			s = (which == 0) ? byp_out : (which == 1) ? src_load : int_n;
		end while (s !== v && cyc < lim);
		if (s !== v) begin
			chk1(s, v);
			wrap_up();
		end
	endtask : wait_sig
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic pulse_ack();
		@(posedge ref_clk);
		irq_ack <= 1'h1;
		@(posedge ref_clk);
		irq_ack <= 1'h0;
		tick(2);
	endtask : pulse_ack
	logic [7:0] v;
	initial begin
		n_fail = 0;
		n_compared = 0;
		sys_rst = 1'h1;
		{wr_en, rd_en, irq_ack} = 3'h0;
		det_lvl = 1'h1;
		addr = 8'h00;
		wdata = 8'h00;
		{gp_out, gp_oe, bs_act, bs_out, bs_oe} = 10'h000;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'h0;
		// pull-up default visible through the filter before enabling
		rd(pbcc_pkg::PBCC_REG_ADDR, v);
		chk8(v, 8'h03);
		rd(8'h24, v);
		chk8(v, 8'h00);
		// disabled: stored bits leave the pins to general port control
		@(posedge ref_clk);
		gp_out <= 2'h0;
		gp_oe  <= 2'h1;
		wr(pbcc_pkg::PBCC_REG_ADDR, 8'h40);
		tick(8);
		chk1(byp_oe, 1'h1);
		chk1(byp_out, 1'h0);
		chk1(det_oe, 1'h0);
		rd(pbcc_pkg::PBCC_REG_ADDR, v);
		chk8(v, 8'h41);
		// enable with the default force value; bit 0 write is ignored
		wr(pbcc_pkg::PBCC_REG_ADDR, 8'h82);
		chk1(byp_oe, 1'h1);
		chk1(byp_out, 1'h1);
		chk1(det_oe, 1'h0);
		rd(pbcc_pkg::PBCC_REG_ADDR, v);
		chk8(v, 8'h83);
		wr(pbcc_pkg::PBCC_REG_ADDR, 8'h80);
		chk1(byp_out, 1'h0);
		chk1(byp_mode, 1'h1);
		wr(pbcc_pkg::PBCC_REG_ADDR, 8'h82);
		chk1(byp_mode, 1'h0);
		// general drive loses to the channel's own drive while enabled
		@(posedge ref_clk);
		gp_oe <= 2'h3;
		tick(2);
		chk1(byp_out, 1'h1);
		chk1(det_oe, 1'h0);
		// bypass select on both pins, detect pin driven high by it
		@(posedge ref_clk);
		bs_act <= 2'h3;
		bs_out <= 2'h2;
		bs_oe  <= 2'h3;
		tick(2);
		chk1(byp_out, 1'h0);
		chk1(det_out, 1'h1);
		chk1(det_oe, 1'h1);
		@(posedge ref_clk);
		bs_act <= 2'h0;
		gp_oe  <= 2'h1;
		// loss of signal without interrupt enable: clear, no interrupt
		@(posedge ref_clk);
		det_lvl <= 1'h0;
		wait_sig(0, 1'h0, pbcc_pkg::PBCC_LOSS_LAT_CYC);
		tick(12);
		chk1(int_n, 1'h1);
		// a software set while signal is absent is overridden
		wr(pbcc_pkg::PBCC_REG_ADDR, 8'h82);
		rd(pbcc_pkg::PBCC_REG_ADDR, v);
		chk8(v, 8'h80);
		chk1(byp_out, 1'h0);
		@(posedge ref_clk);
		det_lvl <= 1'h1;
		tick(12);
		chk1(int_n, 1'h1);
		wr(pbcc_pkg::PBCC_REG_ADDR, 8'hC2);
		// three-sample glitch is swallowed by the four-deep filter
		@(posedge ref_clk);
		det_lvl <= 1'h0;
		tick(2);
		@(posedge ref_clk);
		det_lvl <= 1'h1;
		tick(12);
		chk1(int_n, 1'h1);
		chk1(byp_out, 1'h1);
		// real loss: interrupt, source value, bypass within budget
		@(posedge ref_clk);
		det_lvl <= 1'h0;
		wait_sig(1, 1'h1, pbcc_pkg::PBCC_LOSS_LAT_CYC);
		chk1(src_load, 1'h1);
		chk8(src_val, pbcc_pkg::PBCC_REG_ADDR);
		chk1(int_n, 1'h0);
		wait_sig(0, 1'h0, pbcc_pkg::PBCC_LOSS_LAT_CYC - cyc);
		// the source load is a single-cycle pulse
		chk1(src_load, 1'h0);
		pulse_ack();
		chk1(int_n, 1'h1);
		// signal return is a transition too
		@(posedge ref_clk);
		det_lvl <= 1'h1;
		wait_sig(2, 1'h0, pbcc_pkg::PBCC_LOSS_LAT_CYC);
		pulse_ack();
		chk1(int_n, 1'h1);
		rd(pbcc_pkg::PBCC_REG_ADDR, v);
		chk8(v, 8'hC1);
		wrap_up();
	end
endmodule : test_port_bypass_control_channel
